//--- rtl/srsm_params.svh
// Register map, field positions, reset values and sizes of the receive slot mapper
`ifndef SRSM_PARAMS_SVH
`define SRSM_PARAMS_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define SRSM_IDX_CH6     8'h2d
`define SRSM_IDX_CH7     8'h2e
`define SRSM_IDX_CH8     8'h2f
`define SRSM_IDX_CTRL    8'h30
`define SRSM_IDX_STAT    8'h31

// =====================================================================
// Reset values
`define SRSM_RST_CH6     8'h05
`define SRSM_RST_CH7     8'h06
`define SRSM_RST_CH8     8'h07
`define SRSM_RST_CTRL    8'h00

// =====================================================================
// Field positions
`define SRSM_RSVD_BIT    7
`define SRSM_ROUTE_HI    6
`define SRSM_ROUTE_LO    5
`define SRSM_SLOT_HI     4
`define SRSM_SLOT_LO     0
`define SRSM_HALF_BIT    4
`define SRSM_FMT_BIT     0

// =====================================================================
// Sizes
`define SRSM_DATA_W      32
`define SRSM_FIFO_DEPTH  8
`define SRSM_NUM_CH      3

`endif

//--- rtl/srsm_pkg.sv
// Types shared by the receive slot mapper files
package srsm_pkg;

    // =================================================================
    // Route selector codes
    typedef enum logic [1:0]
    {
        SRSM_ROUTE_OFF  = 2'b00,
        SRSM_ROUTE_DAC  = 2'b01,
        SRSM_ROUTE_LOOP = 2'b10,
        SRSM_ROUTE_LINK = 2'b11
    } srsm_route_e;

    // =================================================================
    // Register bus states
    typedef enum logic
    {
        SRSM_BUS_IDLE = 1'b0,
        SRSM_BUS_ACK  = 1'b1
    } srsm_bus_e;

    typedef logic [7:0] srsm_reg_t;

endpackage : srsm_pkg

//--- rtl/srsm_fifo.sv
// Parameterised valid/ready FIFO between slot capture and the output stage
`timescale 1ns/10ps

module srsm_fifo
    import srsm_pkg::*;
#(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // Fill side
    input  wire logic                       in_valid,
    output      logic                       in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    // Drain side
    output      logic                       out_valid,
    input  wire logic                       out_ready,
    output      logic [WIDTH-1:0]           out_data,
    // Fill level
    output      logic [$clog2(DEPTH):0]     level
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_ff;
    logic [AW:0]      rd_ptr_ff;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Extra pointer bit tells full from empty
    assign full      = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    assign empty     = (wr_ptr_ff == rd_ptr_ff);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem[rd_ptr_ff[AW-1:0]];
    assign level     = wr_ptr_ff - rd_ptr_ff;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_ff <= '0;
        end
        else if (push)
        begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_ptr_ff <= '0;
        end
        else if (pop)
        begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

endmodule : srsm_fifo

//--- rtl/srsm_mapper.sv
// Secondary serial port receive slot mapper for input channels 6 to 8
//
// Summary of operation
// - Channel 6 slot field bits 4-0, resets five
// - Codes 16-31: TDM slot, else right minus 16
// - Ch7 selector: off, DAC7, ADC3 loopback, link 2
// - Ch8 selector: off, DAC8, ADC4 loopback, link 3
// - Channel 7 register resets to 0x06
// - Channel 8 register resets to 0x07
// - Bit 7 reserved, reads zero, write zero
// - Ch6 selector: off, DAC6, ADC2 loopback, link 1
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps

`include "srsm_params.svh"

module srsm_mapper
    import srsm_pkg::*;
(
    // Clock and reset
    input  wire logic                       SYS_CLK,
    input  wire logic                       ARST_N,
    // Avalon-MM register slave
    input  wire logic [9:0]                 AVS_ADDRESS,
    input  wire logic                       AVS_READ,
    input  wire logic                       AVS_WRITE,
    input  wire logic [3:0]                 AVS_BYTEENABLE,
    input  wire logic [31:0]                AVS_WRITEDATA,
    output      logic [31:0]                AVS_READDATA,
    output      logic                       AVS_WAITREQUEST,
    // Received slot stream
    input  wire logic                       SLOT_VALID,
    output      logic                       SLOT_READY,
    input  wire logic [4:0]                 SLOT_NUM,
    input  wire logic                       SLOT_RIGHT,
    input  wire logic [`SRSM_DATA_W-1:0]    SLOT_DATA,
    // Routed word stream
    output      logic                       OUT_VALID,
    input  wire logic                       OUT_READY,
    output      logic [3:0]                 OUT_CHAN,
    output      logic [1:0]                 OUT_ROUTE,
    output      logic [`SRSM_DATA_W-1:0]    OUT_DATA
);

    localparam int NCH   = `SRSM_NUM_CH;
    localparam int FW    = `SRSM_DATA_W + 4;
    localparam int LVL_W = $clog2(`SRSM_FIFO_DEPTH) + 1;

    // =================================================================
    // Functions

    // Format-aware slot compare, shared by all channels
    function automatic logic slot_hit(input logic [4:0] sel,
                                      input logic       fmt_two_half,
                                      input logic [4:0] num,
                                      input logic       right);
        logic hit;
        hit = 1'b0;
        if (fmt_two_half)
        begin
            hit = (num[3:0] == sel[3:0]) && (right == sel[`SRSM_HALF_BIT]);
        end
        else
        begin
            hit = (num == sel);
        end
        return hit;
    endfunction : slot_hit

    function automatic logic [1:0] route_of(input srsm_reg_t cfg);
        return cfg[`SRSM_ROUTE_HI:`SRSM_ROUTE_LO];
    endfunction : route_of

    // =================================================================
    // Register bus

    srsm_bus_e          bus_state_ff;
    logic               wait_ff;
    logic [31:0]        rdata_ff;
    srsm_reg_t          cfg_ff [NCH];
    logic               fmt_ff;
    logic [NCH-1:0]     wrote_ff;
    logic [7:0]         idx;
    logic               commit;
    logic [NCH-1:0]     pend_ff;
    logic [LVL_W-1:0]   fifo_level;
    srsm_reg_t          rd_mux;

    assign idx    = AVS_ADDRESS[9:2];
    assign commit = (bus_state_ff == SRSM_BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];

    always_comb
    begin
        case (idx)
            `SRSM_IDX_CH6:  rd_mux = cfg_ff[0];
            `SRSM_IDX_CH7:  rd_mux = cfg_ff[1];
            `SRSM_IDX_CH8:  rd_mux = cfg_ff[2];
            `SRSM_IDX_CTRL: rd_mux = {7'h00, fmt_ff};
            `SRSM_IDX_STAT: rd_mux = {1'b0, pend_ff, fifo_level};
            default:        rd_mux = 8'h00;
        endcase
    end

    // One wait cycle, then one cycle of waitrequest low
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            bus_state_ff <= SRSM_BUS_IDLE;
            wait_ff      <= 1'b1;
        end
        else
        begin
            case (bus_state_ff)
                SRSM_BUS_IDLE:
                begin
                    if (AVS_READ || AVS_WRITE)
                    begin
                        bus_state_ff <= SRSM_BUS_ACK;
                        wait_ff      <= 1'b0;
                    end
                end
                SRSM_BUS_ACK:
                begin
                    bus_state_ff <= SRSM_BUS_IDLE;
                    wait_ff      <= 1'b1;
                end
                default:
                begin
                    bus_state_ff <= SRSM_BUS_IDLE;
                    wait_ff      <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else if ((bus_state_ff == SRSM_BUS_IDLE) && AVS_READ)
        begin
            rdata_ff <= {24'h00_0000, rd_mux};
        end
    end

    // Bit 7 is forced low whatever software writes
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            cfg_ff[0] <= `SRSM_RST_CH6;
            cfg_ff[1] <= `SRSM_RST_CH7;
            cfg_ff[2] <= `SRSM_RST_CH8;
            fmt_ff    <= 1'(`SRSM_RST_CTRL);
            wrote_ff  <= '0;
        end
        else if (commit)
        begin
            case (idx)
                `SRSM_IDX_CH6:
                begin
                    cfg_ff[0]   <= {1'b0, AVS_WRITEDATA[6:0]};
                    wrote_ff[0] <= 1'b1;
                end
                `SRSM_IDX_CH7:
                begin
                    cfg_ff[1]   <= {1'b0, AVS_WRITEDATA[6:0]};
                    wrote_ff[1] <= 1'b1;
                end
                `SRSM_IDX_CH8:
                begin
                    cfg_ff[2]   <= {1'b0, AVS_WRITEDATA[6:0]};
                    wrote_ff[2] <= 1'b1;
                end
                `SRSM_IDX_CTRL:
                begin
                    fmt_ff <= AVS_WRITEDATA[`SRSM_FMT_BIT];
                end
                default:
                begin
                    fmt_ff <= fmt_ff;
                end
            endcase
        end
    end

    assign AVS_WAITREQUEST = wait_ff;
    assign AVS_READDATA    = rdata_ff;

    // =================================================================
    // Slot capture

    logic                       ready_ff;
    logic [NCH-1:0]             cap;
    logic [NCH-1:0]             grant;
    logic [NCH-1:0]             nxt_pend;
    logic [1:0]                 pend_route_ff [NCH];
    logic [`SRSM_DATA_W-1:0]    pend_data_ff [NCH];
    logic                       fifo_in_ready;
    logic [FW-1:0]              fifo_in_data;

    // Disabled channels never capture
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            cap[i] = SLOT_VALID && ready_ff && (route_of(cfg_ff[i]) != SRSM_ROUTE_OFF)
                     && slot_hit(cfg_ff[i][`SRSM_SLOT_HI:`SRSM_SLOT_LO], fmt_ff, SLOT_NUM, SLOT_RIGHT);
        end
    end

    // Lowest channel first; one word per cycle into the FIFO
    always_comb
    begin
        grant        = '0;
        fifo_in_data = '0;
        if (fifo_in_ready)
        begin
            for (int i = NCH - 1; i >= 0; i--)
            begin
                if (pend_ff[i])
                begin
                    grant        = 3'(1 << i);
                    fifo_in_data = {2'(i), pend_route_ff[i], pend_data_ff[i]};
                end
            end
        end
        nxt_pend = cap | (pend_ff & ~grant);
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pend_ff <= '0;
        end
        else
        begin
            pend_ff <= nxt_pend;
        end
    end

    // Stall the source while any captured word waits
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ready_ff <= 1'b0;
        end
        else
        begin
            ready_ff <= ~|nxt_pend;
        end
    end

    // Route is frozen at capture so a later rewrite cannot retag it
    always_ff @(posedge SYS_CLK)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (cap[i])
            begin
                pend_route_ff[i] <= route_of(cfg_ff[i]);
                pend_data_ff[i]  <= SLOT_DATA;
            end
        end
    end

    assign SLOT_READY = ready_ff;

    // =================================================================
    // Buffer and output stage

    logic               fifo_out_valid;
    logic               fifo_out_ready;
    logic [FW-1:0]      fifo_out_data;
    logic               out_valid_ff;
    logic [3:0]         out_chan_ff;
    logic [1:0]         out_route_ff;
    logic [`SRSM_DATA_W-1:0] out_data_ff;

    srsm_fifo #(
        .WIDTH (FW),
        .DEPTH (`SRSM_FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .arst_n    (ARST_N),
        .in_valid  (|pend_ff),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    assign fifo_out_ready = !out_valid_ff || OUT_READY;

    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            out_valid_ff <= 1'b0;
            out_chan_ff  <= 4'h0;
            out_route_ff <= 2'h0;
            out_data_ff  <= '0;
        end
        else if (fifo_out_ready)
        begin
            out_valid_ff <= fifo_out_valid;
            if (fifo_out_valid)
            begin
                out_chan_ff  <= 4'(fifo_out_data[FW-1:FW-2]) + 4'h6; // Channel 6..8
                out_route_ff <= fifo_out_data[FW-3:FW-4];
                out_data_ff  <= fifo_out_data[`SRSM_DATA_W-1:0];
            end
        end
    end

    assign OUT_VALID = out_valid_ff;
    assign OUT_CHAN  = out_chan_ff;
    assign OUT_ROUTE = out_route_ff;
    assign OUT_DATA  = out_data_ff;

    // =================================================================
    // Assertions

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    sequence bus_req_s;
        (AVS_READ || AVS_WRITE) && (bus_state_ff == SRSM_BUS_IDLE);
    endsequence

    sequence bus_ack_s;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence

    bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
        else $error("Bus request not answered in one cycle");

    rst_ch6_a: assert property (!wrote_ff[0] |-> cfg_ff[0] == `SRSM_RST_CH6)
        else $error("Channel 6 register lost reset value");

    rst_ch7_a: assert property (!wrote_ff[1] |-> cfg_ff[1] == `SRSM_RST_CH7)
        else $error("Channel 7 register lost reset value");

    rst_ch8_a: assert property (!wrote_ff[2] |-> cfg_ff[2] == `SRSM_RST_CH8)
        else $error("Channel 8 register lost reset value");

    rsvd_read_a: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[`SRSM_RSVD_BIT] == 1'b0)
        else $error("Reserved bit read as one");

    cfg_write_a: assert property (commit && idx == `SRSM_IDX_CH7 |=>
        cfg_ff[1] == {1'b0, $past(AVS_WRITEDATA[6:0])})
        else $error("Channel 7 write not stored");

    ch6_route_a: assert property ($rose(pend_ff[0]) |->
        $past(route_of(cfg_ff[0])) != SRSM_ROUTE_OFF && pend_route_ff[0] == $past(route_of(cfg_ff[0])))
        else $error("Channel 6 captured while disabled or wrong route");

    ch7_word_a: assert property ($rose(pend_ff[1]) |->
        pend_data_ff[1] == $past(SLOT_DATA) && pend_route_ff[1] == $past(route_of(cfg_ff[1])))
        else $error("Channel 7 word or route wrong");

    ch8_word_a: assert property ($rose(pend_ff[2]) |->
        pend_data_ff[2] == $past(SLOT_DATA) && pend_route_ff[2] == $past(route_of(cfg_ff[2])))
        else $error("Channel 8 word or route wrong");

    right_half_a: assert property ($rose(pend_ff[1]) && $past(fmt_ff) |->
        $past(SLOT_RIGHT) == $past(cfg_ff[1][`SRSM_HALF_BIT]) && $past(SLOT_NUM[3:0]) == $past(cfg_ff[1][3:0]))
        else $error("Two-half slot match wrong");

endmodule : srsm_mapper

//--- dv/srsm_partner.sv
// Far-side model: slot source of the serial receiver and sink of routed words
`timescale 1ns/10ps
`include "srsm_params.svh"

module srsm_partner
    import srsm_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    // Slot source
    output      logic                    slot_valid,
    input  wire logic                    slot_ready,
    output      logic [4:0]              slot_num,
    output      logic                    slot_right,
    output      logic [`SRSM_DATA_W-1:0] slot_data,
    // Routed word sink
    input  wire logic                    out_valid,
    output      logic                    out_ready,
    input  wire logic [3:0]              out_chan,
    input  wire logic [1:0]              out_route,
    input  wire logic [`SRSM_DATA_W-1:0] out_data,
    // Sink pacing
    input  wire logic                    hold,
    input  wire logic                    slow
);
    logic [37:0] got [$];
    logic [1:0]  pace_ff;

    initial
    begin
        slot_valid = 1'b0;
        slot_num   = 5'h00;
        slot_right = 1'b0;
        slot_data  = 32'h0;
    end

    // =====================================================================
    // Slot source
    task automatic send_slot(input logic [4:0] num, input logic rgt, input logic [`SRSM_DATA_W-1:0] d);
        @(posedge clk);
        slot_valid <= 1'b1;
        slot_num   <= num;
        slot_right <= rgt;
        slot_data  <= d;
        do @(posedge clk); while (slot_ready !== 1'b1);
        slot_valid <= 1'b0;
        // Released lines must not keep showing the accepted word
        slot_num   <= ~num;
        slot_data  <= ~d;
    endtask : send_slot

    // =====================================================================
    // Sink, prompt or paced to one cycle in four
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_ready <= 1'b0;
            pace_ff   <= 2'b00;
        end
        else
        begin
            pace_ff   <= pace_ff + 2'b01;
            out_ready <= !hold && (!slow || pace_ff == 2'b00);
            if (out_valid === 1'b1 && out_ready)
                got.push_back({out_chan, out_route, out_data});
        end
    end
endmodule : srsm_partner

//--- dv/srsm_mapper_tb_top.sv
// Self-checking bench for the receive slot mapper
`timescale 1ns/10ps
`include "srsm_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); end end

module srsm_mapper_tb_top;
    localparam logic [9:0] A_CH6  = {`SRSM_IDX_CH6, 2'b00};
    localparam logic [9:0] A_CTRL = {`SRSM_IDX_CTRL, 2'b00};
    localparam logic [9:0] A_STAT = {`SRSM_IDX_STAT, 2'b00};
    localparam logic [9:0] A_BAD  = 10'h3fc;

    logic                    SYS_CLK = 1'b0;
    logic                    ARST_N = 1'b0;
    logic [9:0]              AVS_ADDRESS = 10'h000;
    logic                    AVS_READ = 1'b0;
    logic                    AVS_WRITE = 1'b0;
    logic [3:0]              AVS_BYTEENABLE = 4'h1;
    logic [31:0]             AVS_WRITEDATA = 32'h0;
    logic [31:0]             AVS_READDATA;
    logic                    AVS_WAITREQUEST;
    logic                    SLOT_VALID, SLOT_READY, SLOT_RIGHT, OUT_VALID, OUT_READY;
    logic [4:0]              SLOT_NUM;
    logic [`SRSM_DATA_W-1:0] SLOT_DATA, OUT_DATA;
    logic [3:0]              OUT_CHAN;
    logic [1:0]              OUT_ROUTE;
    logic                    sink_hold = 1'b0;
    logic                    sink_slow = 1'b0;
    logic                    fmt = 1'b0;
    logic [7:0]              cfg [3];
    logic [37:0]             expq [$];
    logic [31:0]             seed = 32'h8326529a;
    int                      bad_count = 0;
    int                      checks_done = 0;

    always #5 SYS_CLK = ~SYS_CLK;

    srsm_mapper u_srsm_mapper (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .SLOT_VALID(SLOT_VALID), .SLOT_READY(SLOT_READY), .SLOT_NUM(SLOT_NUM), .SLOT_RIGHT(SLOT_RIGHT),
        .SLOT_DATA(SLOT_DATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_CHAN(OUT_CHAN),
        .OUT_ROUTE(OUT_ROUTE), .OUT_DATA(OUT_DATA));

    srsm_partner u_srsm_partner (.clk(SYS_CLK), .arst_n(ARST_N), .slot_valid(SLOT_VALID),
        .slot_ready(SLOT_READY), .slot_num(SLOT_NUM), .slot_right(SLOT_RIGHT), .slot_data(SLOT_DATA),
        .out_valid(OUT_VALID), .out_ready(OUT_READY), .out_chan(OUT_CHAN), .out_route(OUT_ROUTE),
        .out_data(OUT_DATA), .hold(sink_hold), .slow(sink_slow));

    // =====================================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic slot_hit(input logic [4:0] fld, input logic [4:0] num, input logic rgt);
        if (fmt)
            return (fld[4] == rgt) && (fld[3:0] == num[3:0]);
        return fld == num;
    endfunction : slot_hit

    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        AVS_ADDRESS    <= a;
        AVS_WRITE      <= wr;
        AVS_READ       <= !wr;
        AVS_BYTEENABLE <= be;
        AVS_WRITEDATA  <= {24'h0, wd};
        do
        begin
            @(posedge SYS_CLK);
            n++;
        end
        while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
        `CHK(n < 50, 1'b1)
    endtask : bus

    task automatic wr(input logic [9:0] a, input logic [7:0] wd);
        logic [31:0] rd;
        bus(1'b1, a, wd, 4'h1, rd);
    endtask : wr

    task automatic chk_rd(input logic [9:0] a, input logic [7:0] e);
        logic [31:0] rd;
        bus(1'b0, a, 8'h00, 4'h1, rd);
        `CHK(rd, {24'h0, e})
    endtask : chk_rd

    task automatic send(input logic [4:0] num, input logic rgt);
        logic [31:0] d;
        d = rnd();
        for (int c = 0; c < 3; c++)
            if (cfg[c][6:5] != 2'b00 && slot_hit(cfg[c][4:0], num, rgt))
                expq.push_back({4'(c + 6), cfg[c][6:5], d});
        u_srsm_partner.send_slot(num, rgt, d);
    endtask : send

    task automatic drain();
        int n;
        logic [37:0] g;
        logic [37:0] e;
        n = 0;
        while (u_srsm_partner.got.size() < expq.size() && n < 2000)
        begin
            @(posedge SYS_CLK);
            n++;
        end
        repeat (6) @(posedge SYS_CLK);
        `CHK(u_srsm_partner.got.size(), expq.size())
        while (expq.size() > 0 && u_srsm_partner.got.size() > 0)
        begin
            g = u_srsm_partner.got.pop_front();
            e = expq.pop_front();
            `CHK(g, e)
        end
        expq.delete();
        u_srsm_partner.got.delete();
    endtask : drain

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        #400000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end

    // =====================================================================
    // Main sequence
    initial
    begin
        logic [31:0] x;
        logic [31:0] rd;
        logic [4:0]  fld;
        repeat (3) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        chk_rd(A_CH6, 8'h05);
        chk_rd(A_CH6 + 10'h004, 8'h06);
        chk_rd(A_CH6 + 10'h008, 8'h07);
        chk_rd(A_CTRL, 8'h00);
        // Deliberate reserved-bit write, then a write with its byte lane off
        bus(1'b1, A_CH6 + 10'h008, 8'hff, 4'h1, rd);
        chk_rd(A_CH6 + 10'h008, 8'h7f);
        bus(1'b1, A_CH6 + 10'h008, 8'h07, 4'h0, rd);
        chk_rd(A_CH6 + 10'h008, 8'h7f);
        wr(A_BAD, 8'h5a);
        chk_rd(A_BAD, 8'h00);
        for (int f = 0; f < 2; f++)
        begin
            fmt = f[0];
            wr(A_CTRL, {7'h00, fmt});
            for (int r = 0; r < 4; r++)
            begin
                x = rnd();
                sink_slow <= x[11];
                for (int c = 0; c < 3; c++)
                begin
                    x = rnd();
                    // Random, then one shared slot, then the format boundaries, then random again
                    fld = (r == 1) ? 5'h1f : (r == 2) ? 5'(5'h0f + c * 16) : x[4:0];
                    cfg[c] = {1'b0, 2'(r + c), fld};
                    wr(A_CH6 + 10'(4 * c), cfg[c]);
                end
                for (int k = 0; k < 16; k++)
                begin
                    x = rnd();
                    fld = cfg[x[1:0] % 3][4:0];
                    if (x[31:30] == 2'b00)
                        send(x[8:4], x[9]);
                    else if (fmt)
                        send({x[9], fld[3:0]}, fld[4]);
                    else
                        send(fld, x[10]);
                end
                drain();
            end
        end
        // Fill the buffer with the sink stalled until slot input is refused
        wr(A_CTRL, 8'h00);
        for (int c = 0; c < 3; c++)
        begin
            cfg[c] = 8'h23;
            wr(A_CH6 + 10'(4 * c), cfg[c]);
        end
        sink_hold <= 1'b1;
        for (int k = 0; k < 3; k++)
            send(5'h03, 1'b0);
        repeat (4) @(posedge SYS_CLK);
        chk_rd(A_STAT, 8'h08);
        fork
            send(5'h03, 1'b0);
        join_none
        repeat (20) @(posedge SYS_CLK);
        `CHK(SLOT_READY, 1'b0)
        sink_hold <= 1'b0;
        drain();
        wrap_up();
    end
endmodule : srsm_mapper_tb_top
